// file: hw/timer0_edge_detect.sv
// edge detector on the external count pin
`timescale 1ns/1ps
`default_nettype none
module timer0_edge_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pin
  input wire logic pin,
  // edge pulses
  output logic rise,
  output logic fall
);
  logic prev_q;
  logic prev_d;

  // remember last pin level
  always_comb begin
    prev_d = pin;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = pin && !prev_q;
  assign fall = !pin && prev_q;
endmodule : timer0_edge_detect
`default_nettype wire

// file: hw/timer0_mode_clock_control.sv
// 8-bit timer0 with mode, clock select, force compare, masks and prescaler sync
// Function
// - mode built from control A and B bits
// - top is 0xFF or compare A per mode
// - compare update: immediate, at top, at bottom
// - overflow at max, bottom or top per mode
// - force compare only in non-pwm modes
// - force bit strobes an immediate output match
// - forced match sets no flag, clears nothing
// - force bits always read zero
// - clock select stops or divides io clock
// - selects 110/111 count pin falling/rising edges
// - count pin counts even when driven out
// - compare B request needs mask, enable, flag
// - compare A request needs mask, enable, flag
// - overflow request needs mask, enable, flag
// - sync mode keeps prescaler reset bits set
// - sync mode cleared drops shared bit, async bit once not busy
// - async reset bit resets third prescaler
// - shared reset bit resets timers 0/1 prescaler
// - io registers answer at offset and minus 0x20
// - flags clear by vector or writing one
// - counter write blocks next compare match
`timescale 1ns/1ps
`default_nettype none
module timer0_mode_clock_control
  import timer0_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // internal io bus
  input wire bus_req_t bus,
  output logic [7:0] rdata,
  // cpu interrupt side
  input wire logic global_irq_enable,
  input wire flags_t vector_ack,
  output flags_t irq_request,
  // pins
  input wire logic external_count_pin,
  output logic compare_out_a,
  output logic compare_out_b,
  // prescaler resets
  input wire logic async_reset_busy,
  output logic shared_prescaler_reset,
  output logic async_prescaler_reset
);
  // ==========================================
  // state
  logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, mask_q, mask_d;
  logic [7:0] cnt_q, cnt_d, rdata_q, rdata_d;
  logic [7:0] cmp_buf_q [2], cmp_buf_d [2], cmp_act_q [2], cmp_act_d [2];
  logic [1:0] out_q, out_d;
  logic up_q, up_d, block_q, block_d;
  logic tsm_q, tsm_d, psr_async_q, psr_async_d, psr_shared_q, psr_shared_d;
  flags_t flags_q, flags_d, irq_q, irq_d;

  // ==========================================
  // decode
  wave_mode_t mode;
  clock_sel_t csel;
  logic [8:0] map;
  logic wr_hit, pre_tick, rise, fall, tick, pwm, phase, fast;
  logic [7:0] top;

  assign mode = wave_mode_t'({ctrl_b_q[B_WAVE2], ctrl_a_q[1:0]});
  assign csel = clock_sel_t'(ctrl_b_q[2:0]);
  assign map = map_addr(bus);
  assign wr_hit = bus.wr && map[8];
  assign pwm = is_pwm(mode);
  assign phase = (mode == WM_PHASE_FF) || (mode == WM_PHASE_OCR);
  assign fast = (mode == WM_FAST_FF) || (mode == WM_FAST_OCR);
  // top source
  assign top = ((mode == WM_CTC) || (mode == WM_PHASE_OCR) || (mode == WM_FAST_OCR))
               ? cmp_act_q[0] : COUNT_MAX;

  // ==========================================
  // clock sources
  timer0_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_prescaler (
    .clk(clk),
    .rstn(rstn),
    .clear(psr_shared_q),
    .sel(csel),
    .tick(pre_tick)
  );

  // pin is sampled regardless of its direction
  timer0_edge_detect u_edge (
    .clk(clk),
    .rstn(rstn),
    .pin(external_count_pin),
    .rise(rise),
    .fall(fall)
  );

  // counter clock selection
  always_comb begin
    unique case (csel)
      CS_EXT_FALL: tick = fall;
      CS_EXT_RISE: tick = rise;
      default: tick = pre_tick;
    endcase
  end

  // ==========================================
  // counter, compare, waveform and register next state
  always_comb begin
    logic [2:0] hit;
    logic at_top, wrap, ovf;
    logic [1:0] com;
    hit = '0;
    at_top = 1'b0;
    wrap = 1'b0;
    ovf = 1'b0;
    com = '0;
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    cmp_buf_d = cmp_buf_q;
    cmp_act_d = cmp_act_q;
    out_d = out_q;
    up_d = up_q;
    block_d = block_q;
    tsm_d = tsm_q;
    flags_d = flags_q;
    // compare matches, blocked after a counter write
    for (int ch = 0; ch < 2; ch++) begin
      hit[ch] = tick && !block_q && (cnt_q == cmp_act_q[ch]);
    end
    // counting sequence
    if (tick) begin
      block_d = 1'b0;
      at_top = (cnt_q == top);
      if (phase) begin
        if (up_q) begin
          if (at_top) begin
            up_d = 1'b0;
            cnt_d = cnt_q - 8'h01;
            cmp_act_d = cmp_buf_q;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end else if (cnt_q == COUNT_BOTTOM) begin
          up_d = 1'b1;
          cnt_d = cnt_q + 8'h01;
          ovf = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end else begin
        wrap = at_top || (cnt_q == COUNT_MAX);
        cnt_d = at_top ? COUNT_BOTTOM : cnt_q + 8'h01;
        ovf = (mode == WM_FAST_OCR) ? at_top : (cnt_q == COUNT_MAX);
        if (fast && wrap) begin
          cmp_act_d = cmp_buf_q;
        end
      end
    end
    // waveform outputs per channel
    for (int ch = 0; ch < 2; ch++) begin
      com = (ch == 0) ? ctrl_a_q[7:6] : ctrl_a_q[5:4];
      if (!pwm) begin
        if (hit[ch]) begin
          out_d[ch] = match_action(out_q[ch], com);
        end
      end else if (com[1]) begin
        if (fast && hit[ch]) begin
          out_d[ch] = com[0];
        end else if (fast && wrap) begin
          out_d[ch] = ~com[0];
        end else if (phase && hit[ch]) begin
          out_d[ch] = up_q ? com[0] : ~com[0];
        end
      end else if (com[0] && ctrl_b_q[B_WAVE2] && ch == 0 && hit[ch]) begin
        out_d[ch] = ~out_q[ch];
      end
    end
    // immediate compare update outside pwm
    if (!pwm) begin
      cmp_act_d = cmp_buf_q;
    end
    // flags: hardware set wins over any clear
    flags_d = flags_q & ~vector_ack;
    if (wr_hit && map[7:0] == OFS_FLAGS) begin
      flags_d = flags_d & ~flags_t'(bus.wdata[2:0]);
    end
    flags_d.ovf = flags_d.ovf | ovf;
    flags_d.cmp_a = flags_d.cmp_a | hit[0];
    flags_d.cmp_b = flags_d.cmp_b | hit[1];
    // register writes
    if (wr_hit) begin
      unique case (map[7:0])
        OFS_CTRL_A: ctrl_a_d = bus.wdata & CTRL_A_MASK;
        OFS_CTRL_B: begin
          ctrl_b_d = bus.wdata & CTRL_B_MASK;
          // forced match: output only, no flag, no clear
          if (!pwm) begin
            if (bus.wdata[B_FORCE_A]) begin
              out_d[0] = match_action(out_q[0], ctrl_a_q[7:6]);
            end
            if (bus.wdata[B_FORCE_B]) begin
              out_d[1] = match_action(out_q[1], ctrl_a_q[5:4]);
            end
          end
        end
        OFS_COUNT: begin
          cnt_d = bus.wdata;
          block_d = 1'b1;
        end
        OFS_CMP_A: cmp_buf_d[0] = bus.wdata;
        OFS_CMP_B: cmp_buf_d[1] = bus.wdata;
        OFS_MASK: mask_d = bus.wdata & IRQ_MASK_BITS;
        OFS_SYNC: tsm_d = bus.wdata[B_TSM];
        default: ;
      endcase
    end
    if (!pwm) begin
      cmp_act_d = cmp_buf_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_q <= RESET_VAL;
      ctrl_b_q <= RESET_VAL;
      mask_q <= RESET_VAL;
      cnt_q <= RESET_VAL;
      cmp_buf_q <= '{RESET_VAL, RESET_VAL};
      cmp_act_q <= '{RESET_VAL, RESET_VAL};
      out_q <= '0;
      up_q <= 1'b1;
      block_q <= 1'b0;
      tsm_q <= 1'b0;
      flags_q <= '0;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      cmp_buf_q <= cmp_buf_d;
      cmp_act_q <= cmp_act_d;
      out_q <= out_d;
      up_q <= up_d;
      block_q <= block_d;
      tsm_q <= tsm_d;
      flags_q <= flags_d;
    end
  end

  // ==========================================
  // prescaler reset bits
  always_comb begin
    psr_shared_d = psr_shared_q;
    psr_async_d = psr_async_q;
    if (wr_hit && map[7:0] == OFS_SYNC) begin
      psr_shared_d = bus.wdata[B_PSR_SHARED];
      psr_async_d = bus.wdata[B_PSR_ASYNC];
    end else if (!tsm_q) begin
      // shared: one clock of reset, then self-clear; async: held until async_reset_busy drops
      psr_shared_d = 1'b0;
      psr_async_d = psr_async_q && async_reset_busy;
    end
    // while in sync mode both bits simply hold
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psr_shared_q <= 1'b0;
      psr_async_q <= 1'b0;
    end else begin
      psr_shared_q <= psr_shared_d;
      psr_async_q <= psr_async_d;
    end
  end

  // ==========================================
  // interrupt requests and read data
  always_comb begin
    irq_d.cmp_b = global_irq_enable && mask_q[2] && flags_q.cmp_b;
    irq_d.cmp_a = global_irq_enable && mask_q[1] && flags_q.cmp_a;
    irq_d.ovf = global_irq_enable && mask_q[0] && flags_q.ovf;
    rdata_d = rdata_q;
    if (bus.rd) begin
      rdata_d = RESET_VAL;
      if (map[8]) begin
        unique case (map[7:0])
          OFS_CTRL_A: rdata_d = ctrl_a_q;
          OFS_CTRL_B: rdata_d = ctrl_b_q;
          OFS_COUNT: rdata_d = cnt_q;
          OFS_CMP_A: rdata_d = cmp_buf_q[0];
          OFS_CMP_B: rdata_d = cmp_buf_q[1];
          OFS_FLAGS: rdata_d = {5'h00, flags_q};
          OFS_MASK: rdata_d = mask_q;
          OFS_SYNC: rdata_d = {tsm_q, 5'h00, psr_async_q, psr_shared_q};
          default: rdata_d = RESET_VAL;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= '0;
      rdata_q <= RESET_VAL;
    end else begin
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // outputs
  assign rdata = rdata_q;
  assign irq_request = irq_q;
  assign compare_out_a = out_q[0];
  assign compare_out_b = out_q[1];
  assign shared_prescaler_reset = psr_shared_q;
  assign async_prescaler_reset = psr_async_q;
endmodule : timer0_mode_clock_control
`default_nettype wire

// file: hw/timer0_pkg.sv
// shared constants, types and helpers of the timer0 control block
package timer0_pkg;
  // ==========================================
  // register map (data-space offsets)
  localparam logic [7:0] OFS_SYNC = 8'h43;
  localparam logic [7:0] OFS_CTRL_A = 8'h44;
  localparam logic [7:0] OFS_CTRL_B = 8'h45;
  localparam logic [7:0] OFS_COUNT = 8'h46;
  localparam logic [7:0] OFS_CMP_A = 8'h47;
  localparam logic [7:0] OFS_CMP_B = 8'h48;
  localparam logic [7:0] OFS_FLAGS = 8'h35;
  localparam logic [7:0] OFS_MASK = 8'h6e;
  localparam logic [7:0] IO_OFFSET = 8'h20;
  localparam logic [7:0] IO_LAST = 8'h3f;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // ==========================================
  // field positions
  localparam int B_FORCE_A = 7;
  localparam int B_FORCE_B = 6;
  localparam int B_WAVE2 = 3;
  localparam int B_TSM = 7;
  localparam int B_PSR_ASYNC = 1;
  localparam int B_PSR_SHARED = 0;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0f;
  localparam logic [7:0] SYNC_MASK = 8'h83;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h07;
  localparam int PRESCALE_WIDTH = 10;

  // ==========================================
  // modes and clock sources
  typedef enum logic [2:0] {
    WM_NORMAL = 3'b000, WM_PHASE_FF = 3'b001, WM_CTC = 3'b010, WM_FAST_FF = 3'b011,
    WM_RES4 = 3'b100, WM_PHASE_OCR = 3'b101, WM_RES6 = 3'b110, WM_FAST_OCR = 3'b111
  } wave_mode_t;

  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
  } clock_sel_t;

  // ==========================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic io_space;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } flags_t;

  // ==========================================
  // helpers
  function automatic logic is_pwm(input wave_mode_t m);
    is_pwm = (m == WM_PHASE_FF) || (m == WM_FAST_FF) || (m == WM_PHASE_OCR) || (m == WM_FAST_OCR);
  endfunction : is_pwm

  function automatic logic prescale_tick(input logic [PRESCALE_WIDTH-1:0] c, input clock_sel_t cs);
    unique case (cs)
      CS_DIV1: prescale_tick = 1'b1;
      CS_DIV8: prescale_tick = &c[2:0];
      CS_DIV64: prescale_tick = &c[5:0];
      CS_DIV256: prescale_tick = &c[7:0];
      CS_DIV1024: prescale_tick = &c[9:0];
      default: prescale_tick = 1'b0;
    endcase
  endfunction : prescale_tick

  // non-pwm output action: toggle, clear or set
  function automatic logic match_action(input logic cur, input logic [1:0] com);
    unique case (com)
      2'b01: match_action = ~cur;
      2'b10: match_action = 1'b0;
      2'b11: match_action = 1'b1;
      default: match_action = cur;
    endcase
  endfunction : match_action

  // map a bus address to its data-space offset; msb marks a valid address
  function automatic logic [8:0] map_addr(input bus_req_t r);
    if (!r.io_space) begin
      map_addr = {1'b1, r.addr};
    end else begin
      map_addr = {(r.addr <= IO_LAST), 8'(r.addr + IO_OFFSET)};
    end
  endfunction : map_addr
endpackage : timer0_pkg

// file: hw/timer0_prescaler.sv
// shared prescaler counter producing the selected divided tick
`timescale 1ns/1ps
`default_nettype none
module timer0_prescaler
  import timer0_pkg::*;
#(
  parameter int WIDTH = PRESCALE_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic clear,
  input wire clock_sel_t sel,
  // tick out
  output logic tick
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // free-running count, held at zero while reset is asserted
  always_comb begin
    cnt_d = clear ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // no tick while the prescaler is held
  assign tick = !clear && prescale_tick(cnt_q, sel);
endmodule : timer0_prescaler
`default_nettype wire

// file: sim/timer0_mode_clock_control_properties.sv
// concurrent checks on the timer0 control block ports
`timescale 1ns/1ps
`default_nettype none
module timer0_mode_clock_control_properties
  import timer0_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus and interrupts
  input wire bus_req_t bus,
  input wire logic [7:0] rdata,
  input wire logic global_irq_enable,
  input wire flags_t vector_ack,
  input wire flags_t irq_request,
  // pins and prescaler resets
  input wire logic external_count_pin,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  input wire logic async_reset_busy,
  input wire logic shared_prescaler_reset,
  input wire logic async_prescaler_reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // write to the sync control register in either address space
  wire logic wr_sync = bus.wr && (bus.io_space ? bus.addr == (OFS_SYNC - IO_OFFSET) : bus.addr == OFS_SYNC);

  // ==========================================
  // sequences
  sequence s_shared_pulse;
    shared_prescaler_reset ##1 !shared_prescaler_reset;
  endsequence
  sequence s_both_held;
    (shared_prescaler_reset && async_prescaler_reset) [*2];
  endsequence

  // ==========================================
  // properties
  property p_irq_b;
    irq_request.cmp_b |-> $past(global_irq_enable);
  endproperty
  property p_irq_a;
    irq_request.cmp_a |-> $past(global_irq_enable);
  endproperty
  property p_irq_ovf;
    $rose(irq_request.ovf) |-> $past(global_irq_enable);
  endproperty
  property p_ack_clear;
    vector_ack.ovf |=> ##1 !irq_request.ovf;
  endproperty
  property p_force_zero;
    bus.rd && !bus.io_space && bus.addr == OFS_CTRL_B |=> rdata[7:6] == 2'b00;
  endproperty
  property p_unmapped;
    bus.rd && bus.io_space && bus.addr > IO_LAST |=> rdata == 8'h00;
  endproperty
  property p_sync_hold;
    wr_sync && bus.wdata == 8'h83 |=> s_both_held;
  endproperty
  property p_sync_drop;
    wr_sync && bus.wdata == 8'h00 && !async_reset_busy |=> !shared_prescaler_reset && !async_prescaler_reset;
  endproperty
  property p_shared_pulse;
    wr_sync && bus.wdata == 8'h01 |=> s_shared_pulse;
  endproperty
  property p_async_busy;
    async_prescaler_reset && async_reset_busy && !wr_sync |=> async_prescaler_reset;
  endproperty

  a_irq_b: assert property (p_irq_b) else $error("compare b request without enable");
  a_irq_a: assert property (p_irq_a) else $error("compare a request without enable");
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request without enable");
  a_ack_clear: assert property (p_ack_clear) else $error("overflow request kept after ack");
  a_force_zero: assert property (p_force_zero) else $error("force bits read nonzero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped io read nonzero");
  a_sync_hold: assert property (p_sync_hold) else $error("resets not held in sync mode");
  a_sync_drop: assert property (p_sync_drop) else $error("resets not dropped");
  a_shared_pulse: assert property (p_shared_pulse) else $error("shared reset not one cycle");
  a_async_busy: assert property (p_async_busy) else $error("async reset dropped while busy");
endmodule : timer0_mode_clock_control_properties

bind timer0_mode_clock_control timer0_mode_clock_control_properties chk (.clk(clk), .rstn(rstn), .bus(bus),
  .rdata(rdata), .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .irq_request(irq_request),
  .external_count_pin(external_count_pin), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
  .async_reset_busy(async_reset_busy), .shared_prescaler_reset(shared_prescaler_reset),
  .async_prescaler_reset(async_prescaler_reset));
`default_nettype wire

// file: sim/timer0_mode_clock_control_test.sv
// self-checking bench for the timer0 control block
`timescale 1ns/1ps
`default_nettype none
module timer0_mode_clock_control_test
  import timer0_pkg::*;
;
  logic clk, rstn, global_irq_enable, external_count_pin, async_reset_busy;
  logic compare_out_a, compare_out_b, shared_prescaler_reset, async_prescaler_reset;
  bus_req_t bus;
  flags_t vector_ack, irq_request;
  logic [7:0] rdata, v, w;
  int n_fail = 0, comparisons = 0, cycles = 0;
  int div[5] = '{1, 8, 64, 256, 1024};
  logic [2:0] om[4] = '{3'h0, 3'h3, 3'h7, 3'h1};
  logic [7:0] os[4] = '{8'hfe, 8'hfe, 8'h7e, 8'hfe};
  int ow[4] = '{8, 8, 8, 300};
  logic [1:0] cm[3] = '{2'h2, 2'h3, 2'h1};

  timer0_mode_clock_control uut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .irq_request(irq_request),
    .external_count_pin(external_count_pin), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
    .async_reset_busy(async_reset_busy), .shared_prescaler_reset(shared_prescaler_reset),
    .async_prescaler_reset(async_prescaler_reset));

  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================
  // tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
    @(posedge clk);
    bus <= '{addr: a, io_space: io, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic io = 1'b0);
    @(posedge clk);
    bus <= '{addr: a, io_space: io, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    #1 v = rdata;
  endtask : rd
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp, input logic io = 1'b0);
    rd(a, io);
    check(name, v, exp);
  endtask : rchk
  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask : done_test
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ==========================================
  // main sequence
  initial begin
    rstn = 1'b0;
    bus = '0;
    global_irq_enable = 1'b0;
    vector_ack = '0;
    external_count_pin = 1'b0;
    async_reset_busy = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // reset values, reserved and strobe bits, io aliases
    rchk("sync reset", OFS_SYNC, 8'h00);
    rchk("ctrl b reset", OFS_CTRL_B, 8'h00);
    rchk("mask reset", OFS_MASK, 8'h00);
    wr(OFS_MASK, 8'hff);
    rchk("mask bits", OFS_MASK, 8'h07);
    wr(OFS_CTRL_B, 8'hc0);
    rchk("force read", OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_B - IO_OFFSET, 8'h0a, 1'b1);
    rchk("io write", OFS_CTRL_B, 8'h0a);
    rchk("io read", OFS_CTRL_B - IO_OFFSET, 8'h0a, 1'b1);
    rchk("io unmapped", 8'h40, 8'h00, 1'b1);
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_MASK, 8'h00);
    done_test("registers");
    // every prescaler ratio over sixteen counts
    for (int i = 0; i < 5; i++) begin
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CTRL_B, 8'(i + 1));
      repeat (16 * div[i]) @(posedge clk);
      wr(OFS_CTRL_B, 8'h00);
      rd(OFS_COUNT);
      check("prescaled count", 8'(v >= 8'd15 && v <= 8'd20), 8'h01);
    end
    w = v;
    repeat (20) @(posedge clk);
    rchk("stopped count", OFS_COUNT, w);
    done_test("prescaler");
    // count pin: five falls, six rises
    for (int e = 0; e < 2; e++) begin
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CTRL_B, 8'(6 + e));
      for (int p = 0; p < 11; p++) begin
        external_count_pin <= ~external_count_pin;
        repeat (4) @(posedge clk);
      end
      wr(OFS_CTRL_B, 8'h00);
      external_count_pin <= 1'b0;
      rchk("pin edges", OFS_COUNT, 8'(5 + e));
    end
    done_test("count pin");
    // overflow point per mode, request and vector clear
    wr(OFS_CMP_A, 8'h80);
    wr(OFS_MASK, 8'h01);
    global_irq_enable <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTRL_A, {6'h00, om[m][1:0]});
      wr(OFS_COUNT, os[m]);
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_CTRL_B, {4'h0, om[m][2], 3'b001});
      repeat (ow[m]) @(posedge clk);
      wr(OFS_CTRL_B, {4'h0, om[m][2], 3'b000});
      check("overflow request", 8'(irq_request.ovf), 8'h01);
      vector_ack <= 3'b001;
      @(posedge clk);
      vector_ack <= 3'b000;
      rd(OFS_FLAGS);
      check("flag after vector", v & 8'h01, 8'h00);
    end
    done_test("overflow");
    // forced matches: clear, set, toggle, then refused in pwm
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CMP_B, 8'h40);
    wr(OFS_COUNT, 8'h20);
    wr(OFS_FLAGS, 8'h07);
    for (int c = 0; c < 3; c++) begin
      wr(OFS_CTRL_A, {cm[c], cm[c], 4'h2});
      wr(OFS_CTRL_B, 8'hc0);
      repeat (2) @(posedge clk);
      check("forced outputs", {6'h00, compare_out_a, compare_out_b}, (c == 1) ? 8'h03 : 8'h00);
    end
    rchk("forced no flag", OFS_FLAGS, 8'h00);
    rchk("forced no clear", OFS_COUNT, 8'h20);
    wr(OFS_CTRL_A, 8'h53);
    wr(OFS_CTRL_B, 8'hc0);
    repeat (2) @(posedge clk);
    check("pwm force refused", {6'h00, compare_out_a, compare_out_b}, 8'h00);
    done_test("force");
    // compare requests, masking, write-one clear
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CMP_A, 8'h05);
    wr(OFS_CMP_B, 8'h08);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_MASK, 8'h06);
    wr(OFS_CTRL_B, 8'h01);
    repeat (12) @(posedge clk);
    wr(OFS_CTRL_B, 8'h00);
    check("compare requests", {5'h00, irq_request}, 8'h06);
    rchk("compare flags", OFS_FLAGS, 8'h06);
    wr(OFS_MASK, 8'h02);
    repeat (2) @(posedge clk);
    check("masked b", {5'h00, irq_request}, 8'h02);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    check("global off", {5'h00, irq_request}, 8'h00);
    wr(OFS_FLAGS, 8'h06);
    rchk("flags cleared", OFS_FLAGS, 8'h00);
    // counter write onto compare a: first tick must not match
    wr(OFS_COUNT, 8'h05);
    wr(OFS_CTRL_B, 8'h01);
    repeat (4) @(posedge clk);
    wr(OFS_CTRL_B, 8'h00);
    rchk("blocked match", OFS_FLAGS, 8'h04);
    done_test("compare requests");
    // prescaler reset control and sync mode
    wr(OFS_SYNC, 8'h83);
    rchk("sync hold", OFS_SYNC, 8'h83);
    check("resets held", {6'h00, shared_prescaler_reset, async_prescaler_reset}, 8'h03);
    wr(OFS_SYNC, 8'h00);
    rchk("sync drop", OFS_SYNC, 8'h00);
    wr(OFS_SYNC, 8'h02);
    async_reset_busy <= 1'b1; // seen from the edge after the write
    repeat (3) @(posedge clk);
    check("async busy", 8'(async_prescaler_reset), 8'h01);
    async_reset_busy <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("async done", OFS_SYNC, 8'h00);
    wr(OFS_SYNC - IO_OFFSET, 8'h01, 1'b1);
    #1 check("shared high", 8'(shared_prescaler_reset), 8'h01);
    rchk("shared pulse", OFS_SYNC, 8'h00);
    done_test("prescaler reset");
    complete_run();
  end
endmodule : timer0_mode_clock_control_test
`default_nettype wire
